// ==== design/ifv_map.svh ====
/*
  Register indexes, byte addresses, reset values, vector addresses and
  stacking counts of the interrupt flag and vector block.
  Assumes a 32-bit Avalon-MM bus with byte addresses, one word per register.
*/
`ifndef IFV_MAP_SVH
`define IFV_MAP_SVH

// Register indexes; the byte address is four times the index
`define IFV_IDX_PEND_LOW 16'hfe04
`define IFV_IDX_PEND_MID 16'hfe05
`define IFV_IDX_PEND_HIGH 16'hfe06
`define IFV_IDX_EVT_STATUS 16'hfe10
`define IFV_IDX_EVT_CLEAR 16'hfe11
`define IFV_IDX_EVT_ENABLE 16'hfe12

// Reset values
`define IFV_RST_PEND 8'h00
`define IFV_RST_EVT 16'h0000
`define IFV_RST_SP 16'h00ff

// Field positions inside the pending registers
`define IFV_LOW_LSB 2
`define IFV_LOW_CNT 6
`define IFV_MID_CNT 8
`define IFV_HIGH_CNT 2

// Vector addresses, high byte at the even address
`define IFV_VEC_RESET 16'hfffe
`define IFV_VEC_SWI 16'hfffc
`define IFV_VEC_IRQ_PIN 16'hfffa
`define IFV_VEC_CLOCK_GEN 16'hfff8
`define IFV_VEC_TIMER_A_CH0 16'hfff6
`define IFV_VEC_TIMER_A_CH1 16'hfff4
`define IFV_VEC_TIMER_A_OVF 16'hfff2
`define IFV_VEC_TIMER_B_CH0 16'hfff0
`define IFV_VEC_TIMER_B_CH1 16'hffee
`define IFV_VEC_TIMER_B_OVF 16'hffec
`define IFV_VEC_SPI_RX 16'hffea
`define IFV_VEC_SPI_TX 16'hffe8
`define IFV_VEC_SCI_ERR 16'hffe6
`define IFV_VEC_SCI_RX 16'hffe4
`define IFV_VEC_SCI_TX 16'hffe2
`define IFV_VEC_KEYPAD 16'hffe0
`define IFV_VEC_ADC_DONE 16'hffde
`define IFV_VEC_TIMEBASE 16'hffdc

// Stacking counts in bytes
`define IFV_INT_PUSH_BYTES 3'h5
`define IFV_CALL_PUSH_BYTES 3'h2

`endif

// ==== design/ifv_pkg.sv ====
/*
  Types shared by the interrupt flag and vector block.
  Assumes ifv_map.svh holds every number.
*/
package ifv_pkg;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [17:0] address;
    logic [31:0] writedata;
  } avs_req_t;

  // Avalon-MM answer to the master
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } avs_rsp_t;

  // Sixteen maskable sources, index 0 is the irq pin (highest)
  typedef logic [15:0] src_vec_t;

  // Which byte of processor state is pushed
  typedef enum logic [2:0] {
    PUSH_PC_LOW = 3'b000,
    PUSH_PC_HIGH = 3'b001,
    PUSH_INDEX_X = 3'b010,
    PUSH_ACC = 3'b011,
    PUSH_CCR = 3'b100
  } push_sel_t;

  // Stacking sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INT_PUSH = 2'b01,
    ST_CALL_PUSH = 2'b10,
    ST_VEC_FETCH = 2'b11
  } stack_state_t;

endpackage : ifv_pkg

// ==== design/interrupt_flag_vector_map.sv ====
/*
  Interrupt flag bookkeeping: pending registers, vector selection by fixed
  priority, a stacking sequencer with stack pointer, and an event interrupt.
  Assumes sources and the core run on i_clk; registers on Avalon-MM.
*/
`timescale 1ns/1ps
`include "ifv_map.svh"

// How it works
// [R1] Low pending register: irq pin..timer_b_ch0 on bits 2..7, bits 1..0 zero.
// [R2] Mid pending register: timer_b_ch1 bit 0 through keypad bit 7, read-only, resets zero.
// [R3] High pending register: timebase bit 1, adc_done bit 0, others zero.
// [R4] Timebase FFDC, adc FFDE, keypad FFE0; timebase has lowest priority.
// [R5] Serial transmit, receive, error vectors at FFE2, FFE4, FFE6.
// [R6] Synchronous serial transmit FFE8, receive FFEA.
// [R7] Second timer overflow FFEC, channel 1 FFEE, channel 0 FFF0.
// [R8] First timer FFF2/FFF4/FFF6, clock generator FFF8, irq pin FFFA.
// [R9] Two-byte vectors high byte even; priority rises with address; reset highest.
// [R10] Interrupt entry pushes five state bytes; upper index byte never saved.
// [R11] Stack pointer decrements per push, increments per pull; call pushes two bytes.
// [R12] Pending flags follow source requests; software writes never change them.
module interrupt_flag_vector_map
  import ifv_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register bus
  input wire avs_req_t i_avs,
  output avs_rsp_t o_avs,
  // Source requests and software interrupt
  input wire src_vec_t i_src_req,
  input wire logic i_swi_req,
  // Core side
  input wire logic i_int_accept,
  input wire logic i_call,
  input wire logic i_pull,
  output logic o_vec_valid,
  output logic [15:0] o_vec_addr_hi,
  output logic [15:0] o_vec_addr_lo,
  output logic o_vec_fetch,
  output logic o_push_valid,
  output push_sel_t o_push_sel,
  output logic [15:0] o_stack_addr,
  output logic [15:0] o_sp,
  // Interrupt
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pending flags

  src_vec_t pend_r;
  src_vec_t pend_d_r;
  logic [7:0] pend_low;
  logic [7:0] pend_mid;
  logic [7:0] pend_high;

  // Flags only follow the sources; no bus path reaches them
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pend_r <= {`IFV_RST_PEND, `IFV_RST_PEND};
      pend_d_r <= {`IFV_RST_PEND, `IFV_RST_PEND};
    end
    else
    begin
      pend_r <= i_src_req; // R12
      pend_d_r <= pend_r;
    end
  end

  assign pend_low = {pend_r[`IFV_LOW_CNT-1:0], 2'h0}; // R1
  assign pend_mid = pend_r[`IFV_LOW_CNT+`IFV_MID_CNT-1:`IFV_LOW_CNT]; // R2
  assign pend_high = {6'h00, pend_r[15:`IFV_LOW_CNT+`IFV_MID_CNT]}; // R3

  ////////////////////////////////////////////////////////////////////////////
  // Vector selection

  // Table indexed by source, index 0 = irq pin
  logic [15:0] vec_tab [16];
  assign vec_tab[0] = `IFV_VEC_IRQ_PIN; // R8
  assign vec_tab[1] = `IFV_VEC_CLOCK_GEN; // R8
  assign vec_tab[2] = `IFV_VEC_TIMER_A_CH0; // R8
  assign vec_tab[3] = `IFV_VEC_TIMER_A_CH1; // R8
  assign vec_tab[4] = `IFV_VEC_TIMER_A_OVF; // R8
  assign vec_tab[5] = `IFV_VEC_TIMER_B_CH0; // R7
  assign vec_tab[6] = `IFV_VEC_TIMER_B_CH1; // R7
  assign vec_tab[7] = `IFV_VEC_TIMER_B_OVF; // R7
  assign vec_tab[8] = `IFV_VEC_SPI_RX; // R6
  assign vec_tab[9] = `IFV_VEC_SPI_TX; // R6
  assign vec_tab[10] = `IFV_VEC_SCI_ERR; // R5
  assign vec_tab[11] = `IFV_VEC_SCI_RX; // R5
  assign vec_tab[12] = `IFV_VEC_SCI_TX; // R5
  assign vec_tab[13] = `IFV_VEC_KEYPAD; // R4
  assign vec_tab[14] = `IFV_VEC_ADC_DONE; // R4
  assign vec_tab[15] = `IFV_VEC_TIMEBASE; // R4

  logic [15:0] vec_sel;
  logic vec_any;

  // Walk from lowest to highest priority so the last hit wins
  always_comb
  begin
    vec_sel = `IFV_VEC_SWI;
    vec_any = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      if (pend_r[i])
      begin
        vec_sel = vec_tab[i]; // R9
        vec_any = 1'b1;
      end
    end
    if (i_swi_req)
    begin
      vec_sel = `IFV_VEC_SWI; // R9
      vec_any = 1'b1;
    end
  end

  // Reset vector shows until the first edge after release
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_vec_addr_hi <= `IFV_VEC_RESET; // R9
      o_vec_addr_lo <= `IFV_VEC_RESET | 16'h0001;
      o_vec_valid <= 1'b0;
    end
    else
    begin
      o_vec_addr_hi <= vec_sel;
      o_vec_addr_lo <= vec_sel | 16'h0001; // R9
      o_vec_valid <= vec_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stacking sequencer

  stack_state_t state_r;
  logic [2:0] push_cnt_r;
  logic [15:0] sp_r;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= ST_IDLE;
      push_cnt_r <= 3'h0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          push_cnt_r <= 3'h0;
          if (i_int_accept)
            state_r <= ST_INT_PUSH;
          else if (i_call)
            state_r <= ST_CALL_PUSH;
        end
        ST_INT_PUSH:
        begin
          push_cnt_r <= push_cnt_r + 3'h1;
          if (push_cnt_r == `IFV_INT_PUSH_BYTES - 3'h1) // R10
            state_r <= ST_VEC_FETCH;
        end
        ST_CALL_PUSH:
        begin
          push_cnt_r <= push_cnt_r + 3'h1;
          if (push_cnt_r == `IFV_CALL_PUSH_BYTES - 3'h1) // R11
            state_r <= ST_IDLE;
        end
        ST_VEC_FETCH:
          state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Upper index byte is never among the pushed bytes
  always_comb
  begin
    o_push_valid = (state_r == ST_INT_PUSH) || (state_r == ST_CALL_PUSH);
    o_vec_fetch = (state_r == ST_VEC_FETCH);
    case (push_cnt_r)
      3'h0: o_push_sel = PUSH_PC_LOW; // R10
      3'h1: o_push_sel = PUSH_PC_HIGH;
      3'h2: o_push_sel = PUSH_INDEX_X;
      3'h3: o_push_sel = PUSH_ACC;
      default: o_push_sel = PUSH_CCR;
    endcase
  end

  // Push writes at the pointer, then moves it down
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      sp_r <= `IFV_RST_SP;
    else if (o_push_valid)
      sp_r <= sp_r - 16'h0001; // R11
    else if (i_pull)
      sp_r <= sp_r + 16'h0001; // R11
  end

  assign o_sp = sp_r;
  assign o_stack_addr = sp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Event status, clear and enable

  src_vec_t evt_status_r;
  src_vec_t evt_enable_r;
  src_vec_t evt_set;
  src_vec_t evt_clr;
  logic bus_wr_take;
  logic bus_rd_take;
  logic [15:0] bus_idx;

  assign evt_set = pend_r & ~pend_d_r;
  assign bus_idx = i_avs.address[17:2];
  assign evt_clr = (bus_wr_take && bus_idx == `IFV_IDX_EVT_CLEAR) ? i_avs.writedata[15:0] : 16'h0000;

  // A new event in the clearing cycle survives
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      evt_status_r <= `IFV_RST_EVT;
    else
      evt_status_r <= (evt_status_r & ~evt_clr) | evt_set;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      evt_enable_r <= `IFV_RST_EVT;
    else if (bus_wr_take && bus_idx == `IFV_IDX_EVT_ENABLE)
      evt_enable_r <= i_avs.writedata[15:0];
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_irq <= 1'b0;
    else
      o_irq <= |((evt_status_r & ~evt_clr | evt_set) & evt_enable_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave, one wait cycle on every access

  logic ack_r;
  logic [31:0] rdata_r;

  assign bus_wr_take = i_avs.write && ack_r;
  assign bus_rd_take = i_avs.read && !ack_r;
  assign o_avs.waitrequest = (i_avs.read || i_avs.write) && !ack_r;
  assign o_avs.readdata = rdata_r;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= (i_avs.read || i_avs.write) && !ack_r;
  end

  // Unmapped and write-only addresses read as zero
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_r <= 32'h0000_0000;
    else if (bus_rd_take)
    begin
      case (bus_idx)
        `IFV_IDX_PEND_LOW: rdata_r <= {24'h000000, pend_low}; // R1
        `IFV_IDX_PEND_MID: rdata_r <= {24'h000000, pend_mid}; // R2
        `IFV_IDX_PEND_HIGH: rdata_r <= {24'h000000, pend_high}; // R3
        `IFV_IDX_EVT_STATUS: rdata_r <= {16'h0000, evt_status_r};
        `IFV_IDX_EVT_ENABLE: rdata_r <= {16'h0000, evt_enable_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_int_start;
    state_r == ST_IDLE && i_int_accept;
  endsequence

  sequence s_five_push;
    o_push_valid [*5] ##1 o_vec_fetch;
  endsequence

  sequence s_call_start;
    state_r == ST_IDLE && !i_int_accept && i_call;
  endsequence

  a_int_five_push: assert property ( // R10
    @(posedge i_clk) disable iff (!i_rst_n) s_int_start |=> s_five_push)
    else $error("interrupt entry did not push five bytes");

  a_call_two_push: assert property ( // R11
    @(posedge i_clk) disable iff (!i_rst_n) s_call_start |=> o_push_valid [*2] ##1 !o_push_valid)
    else $error("call did not push two bytes");

  a_sp_push_down: assert property ( // R11
    @(posedge i_clk) disable iff (!i_rst_n) o_push_valid |=> o_sp == $past(o_sp) - 16'h0001)
    else $error("stack pointer did not decrement on push");

  a_sp_pull_up: assert property ( // R11
    @(posedge i_clk) disable iff (!i_rst_n) !o_push_valid && i_pull |=> o_sp == $past(o_sp) + 16'h0001)
    else $error("stack pointer did not increment on pull");

  a_flag_follow: assert property ( // R12
    @(posedge i_clk) disable iff (!i_rst_n) ##1 pend_r == $past(i_src_req))
    else $error("pending flag does not follow its source");

  a_low_reserved: assert property ( // R1
    @(posedge i_clk) disable iff (!i_rst_n) bus_rd_take && bus_idx == `IFV_IDX_PEND_LOW
      |=> rdata_r[1:0] == 2'h0 && rdata_r[7:2] == $past(pend_r[5:0]))
    else $error("low pending register layout wrong");

  a_mid_layout: assert property ( // R2
    @(posedge i_clk) disable iff (!i_rst_n) bus_rd_take && bus_idx == `IFV_IDX_PEND_MID
      |=> rdata_r[7:0] == $past(pend_r[13:6]))
    else $error("mid pending register layout wrong");

  a_high_layout: assert property ( // R3
    @(posedge i_clk) disable iff (!i_rst_n) bus_rd_take && bus_idx == `IFV_IDX_PEND_HIGH
      |=> rdata_r[7:0] == {6'h00, $past(pend_r[15:14])})
    else $error("high pending register layout wrong");

  a_irq_pin_top: assert property ( // R8
    @(posedge i_clk) disable iff (!i_rst_n) pend_r[0] && !i_swi_req |=> o_vec_addr_hi == 16'hfffa)
    else $error("irq pin does not win among flagged sources");

  a_timebase_low: assert property ( // R4
    @(posedge i_clk) disable iff (!i_rst_n) pend_r == 16'h8000 && !i_swi_req |=> o_vec_addr_hi == 16'hffdc)
    else $error("timebase vector wrong");

  a_swi_over_all: assert property ( // R9
    @(posedge i_clk) disable iff (!i_rst_n) i_swi_req |=> o_vec_addr_hi == 16'hfffc && o_vec_addr_lo == 16'hfffd)
    else $error("software interrupt not above flagged sources");

  a_sci_vec: assert property ( // R5
    @(posedge i_clk) disable iff (!i_rst_n) pend_r == 16'h1000 && !i_swi_req |=> o_vec_addr_hi == 16'hffe2)
    else $error("serial transmit vector wrong");

  a_spi_vec: assert property ( // R6
    @(posedge i_clk) disable iff (!i_rst_n) pend_r == 16'h0100 && !i_swi_req |=> o_vec_addr_hi == 16'hffea)
    else $error("synchronous serial receive vector wrong");

  a_tmrb_vec: assert property ( // R7
    @(posedge i_clk) disable iff (!i_rst_n) pend_r == 16'h0080 && !i_swi_req |=> o_vec_addr_hi == 16'hffec)
    else $error("second timer overflow vector wrong");

endmodule : interrupt_flag_vector_map

// ==== tb/core_model.sv ====
/*
  Behavioural processor core: interrupt entry, subroutine calls and pulls,
  counting the bytes that the block stacks. Assumes the core side on i_clk.
*/
`timescale 1ns/1ps
module core_model
  import ifv_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Block side
  input wire logic i_push_valid,
  input wire push_sel_t i_push_sel,
  input wire logic [15:0] i_stack_addr,
  input wire logic [15:0] i_sp,
  input wire logic i_vec_fetch,
  output logic o_int_accept,
  output logic o_call,
  output logic o_pull
);
  initial
  begin
    o_int_accept = 1'b0;
    o_call = 1'b0;
    o_pull = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One request pulse, then eight cycles watched: enough for five pushes and the fetch
  task automatic enter(input logic is_int, output int pushes, output logic order_ok, output logic fetched);
    logic [15:0] base;
    pushes = 0;
    // A sequence started under reset is not trusted
    order_ok = i_rst_n;
    fetched = 1'b0;
    @(posedge i_clk);
    base = i_sp;
    o_int_accept <= is_int;
    o_call <= ~is_int;
    @(posedge i_clk);
    o_int_accept <= 1'b0;
    o_call <= 1'b0;
    repeat (8)
    begin
      #1;
      if (i_push_valid === 1'b1)
      begin
        if (i_push_sel !== push_sel_t'(pushes[2:0]) || i_stack_addr !== base - 16'(pushes))
          order_ok = 1'b0;
        pushes++;
      end
      if (i_vec_fetch === 1'b1)
        fetched = 1'b1;
      @(posedge i_clk);
    end
  endtask : enter

  task automatic pull_one();
    @(posedge i_clk);
    o_pull <= 1'b1;
    @(posedge i_clk);
    o_pull <= 1'b0;
  endtask : pull_one
endmodule : core_model

// ==== tb/testbench.sv ====
/*
  Self-checking bench for the interrupt flag and vector block.
  Assumes design/ on the include path and core_model compiled first.
*/
`timescale 1ns/1ps
`include "ifv_map.svh"
module testbench
  import ifv_pkg::*;
;
  logic i_clk;
  logic i_rst_n;
  avs_req_t avs;
  avs_rsp_t rsp;
  src_vec_t src;
  logic swi;
  logic acc, call, pull, vvalid, vfetch, pvalid, irq;
  push_sel_t psel;
  logic [15:0] vhi, vlo, saddr, sp;
  logic [31:0] rd;
  int num_errors = 0;
  int n_compared = 0;
  int np;
  logic ok, fet;

  always #12.5 i_clk = ~i_clk;

  interrupt_flag_vector_map i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs(avs), .o_avs(rsp),
    .i_src_req(src), .i_swi_req(swi), .i_int_accept(acc), .i_call(call), .i_pull(pull),
    .o_vec_valid(vvalid), .o_vec_addr_hi(vhi), .o_vec_addr_lo(vlo), .o_vec_fetch(vfetch),
    .o_push_valid(pvalid), .o_push_sel(psel), .o_stack_addr(saddr), .o_sp(sp), .o_irq(irq));
  core_model i_core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_push_valid(pvalid), .i_push_sel(psel),
    .i_stack_addr(saddr), .i_sp(sp), .i_vec_fetch(vfetch), .o_int_accept(acc), .o_call(call),
    .o_pull(pull));

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Request held until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] rdata);
    int n;
    @(posedge i_clk);
    avs.read <= ~wr;
    avs.write <= wr;
    avs.address <= {idx, 2'b00};
    avs.writedata <= wd;
    for (n = 0; n < 20; n++)
    begin
      @(posedge i_clk);
      if (rsp.waitrequest === 1'b0)
        break;
    end
    rdata = rsp.readdata;
    avs.read <= 1'b0;
    avs.write <= 1'b0;
    if (n == 20)
    begin
      num_errors++;
      $display("CHECK FAILED bus answer expected 1 seen 0");
      test_done();
    end
  endtask : bus

  // Flags lag one cycle and the vector two, so three edges settle both
  task automatic src_set(input src_vec_t v, input logic s);
    @(posedge i_clk);
    src <= v;
    swi <= s;
    repeat (3) @(posedge i_clk);
    #1;
  endtask : src_set

  function automatic logic [31:0] pend_exp(input int j, input src_vec_t s);
    case (j)
      0: return {24'h0, s[5:0], 2'b00};
      1: return {24'h0, s[13:6]};
      default: return {30'h0, s[15:14]};
    endcase
  endfunction : pend_exp

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    avs = '0;
    src = '0;
    swi = 1'b0;
    repeat (2) @(posedge i_clk);
    // Reset vector must show for as long as reset is held
    chk("vec reset hi", 32'hfffe, {16'h0, vhi});
    chk("vec reset lo", 32'hffff, {16'h0, vlo});
    chk("vec valid reset", 32'h0, {31'h0, vvalid});
    i_rst_n <= 1'b1;
    #1;
    chk("sp reset", 32'h00ff, {16'h0, sp});
    for (int j = 0; j < 3; j++)
    begin
      bus(1'b0, `IFV_IDX_PEND_LOW + 16'(j), 32'h0, rd);
      chk("pend reset", 32'h0, rd);
    end
    // One source at a time; writes of ones must not disturb any flag
    for (int i = 0; i < 16; i++)
    begin
      src_set(16'h1 << i, 1'b0);
      chk("vec valid", 32'h1, {31'h0, vvalid});
      chk("vec hi", 32'hfffa - 32'(2 * i), {16'h0, vhi});
      chk("vec lo", 32'hfffb - 32'(2 * i), {16'h0, vlo});
      for (int j = 0; j < 3; j++)
      begin
        bus(1'b1, `IFV_IDX_PEND_LOW + 16'(j), 32'hff, rd);
        bus(1'b0, `IFV_IDX_PEND_LOW + 16'(j), 32'h0, rd);
        chk("pending", pend_exp(j, src), rd);
      end
    end
    src_set(16'hffff, 1'b1);
    chk("vec swi", 32'hfffc, {16'h0, vhi});
    src_set(16'hffff, 1'b0);
    chk("vec top", 32'hfffa, {16'h0, vhi});
    src_set(16'hc000, 1'b0);
    chk("vec adc", 32'hffde, {16'h0, vhi});
    src_set(16'h0000, 1'b0);
    chk("vec idle", 32'h0, {31'h0, vvalid});
    bus(1'b0, `IFV_IDX_PEND_HIGH, 32'h0, rd);
    chk("pend clear", 32'h0, rd);
    // Event interrupt: clear, enable, raise, mask, clear
    bus(1'b1, `IFV_IDX_EVT_CLEAR, 32'hffff, rd);
    bus(1'b0, `IFV_IDX_EVT_STATUS, 32'h0, rd);
    chk("evt cleared", 32'h0, rd);
    bus(1'b1, `IFV_IDX_EVT_ENABLE, 32'h1, rd);
    src_set(16'h0001, 1'b0);
    src_set(16'h0000, 1'b0);
    chk("irq raised", 32'h1, {31'h0, irq});
    bus(1'b0, `IFV_IDX_EVT_STATUS, 32'h0, rd);
    chk("evt sticky", 32'h1, rd);
    bus(1'b1, `IFV_IDX_EVT_ENABLE, 32'h2, rd);
    src_set(16'h0000, 1'b0);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, `IFV_IDX_EVT_ENABLE, 32'h1, rd);
    bus(1'b1, `IFV_IDX_EVT_CLEAR, 32'h1, rd);
    src_set(16'h0000, 1'b0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    bus(1'b0, 16'hfe20, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    // Stacking
    i_core.enter(1'b1, np, ok, fet);
    #1;
    chk("int pushes", 32'd5, 32'(np));
    chk("int order", 32'h3, {30'h0, ok, fet});
    chk("sp int", 32'h00fa, {16'h0, sp});
    i_core.enter(1'b0, np, ok, fet);
    #1;
    chk("call pushes", 32'd2, 32'(np));
    chk("call order", 32'h2, {30'h0, ok, fet});
    chk("sp call", 32'h00f8, {16'h0, sp});
    i_core.pull_one();
    #1;
    chk("sp pull", 32'h00f9, {16'h0, sp});
    test_done();
  end
endmodule : testbench
